//--- logic/ppsw_pkg.sv
// package of constants and types for the probe-port serial wake block
// assumes a single 25 MHz clock and synchronous active-low reset
package ppsw_pkg;
  // data format
  localparam int DATA_BITS = 8;
  localparam logic PARITY_ODD = 1'b0; // 0: even parity, 1: odd parity
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  // clock and bit timing
  localparam int CLK_HZ = 25000000;
  localparam int BAUD_DEFAULT = 9600;
  localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / BAUD_DEFAULT);
  // idle timing before the block signals sleep
  localparam int IDLE_MS = 100;
  localparam int IDLE_CYCLES = CLK_HZ / 1000 * IDLE_MS;
  localparam int IDLE_W = 24;
  // frame field layout: bit counters
  localparam logic [3:0] NBITS_FRAME = 4'(DATA_BITS + 1); // data plus parity
  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_START = 1'b0;
  // state codes
  typedef enum logic [1:0] {
    PPSW_IDLE = 2'b00,
    PPSW_START = 2'b01,
    PPSW_BITS = 2'b10,
    PPSW_STOP = 2'b11
  } ppsw_state_t;
endpackage : ppsw_pkg

//--- logic/ppsw_fifo_if.sv
// interface carrying one valid/ready word stream between block modules
// assumes both ends sit on the same clock
`timescale 1ns/10ps
interface ppsw_fifo_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ppsw_fifo_if

//--- logic/ppsw_fifo.sv
// flip-flop FIFO with valid/ready on both sides
// assumes one clock and synchronous active-low reset
`timescale 1ns/10ps
module ppsw_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // streams
  ppsw_fifo_if.snk in_s,
  ppsw_fifo_if.src out_s
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } ppsw_fifo_st_t;
  ppsw_fifo_st_t r;
  ppsw_fifo_st_t next_r;
  logic push;
  logic pop;
  // honest full and empty from the count
  assign in_s.ready = (r.cnt != (AW+1)'(DEPTH));
  assign out_s.valid = (r.cnt != '0);
  assign out_s.data = r.mem[r.rd];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  // pointer and count update
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wr] = in_s.data;
      next_r.wr = r.wr + 1'b1;
    end
    if (pop) begin
      next_r.rd = r.rd + 1'b1;
    end
    if (push && !pop) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end
  // state register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : ppsw_fifo

//--- logic/ppsw_top.sv
// serial link and wake logic for the device side of an eight-pad probe port
// assumes 25 MHz clk_i, synchronous inputs, synchronous active-low reset
//
// Summary of operation
// [RL1] serial out line stays high whenever no frame is being sent
// [RL2] each frame starts with one bit time low
// [RL3] a one data or parity bit is high for one bit time
// [RL4] a zero data or parity bit is low for one bit time
// [RL5] each frame ends with one bit time high stop bit
// [RL6] client sends frames on serial in line in the same format
// [RL7] receiver decodes idle high, start low, one bit time per bit, stop high
// [RL8] low wake hold input wakes the device from sleep
// [RL9] while wake hold is low the device never sleeps
// [RL10] client drives wake hold low before sending frames to a sleeping device
// [RL11] reserved terminals are ignored and never affect operation
// [RL12] bit time from programmable clock divisor; receive samples mid bit
// [RL13] data least significant bit first; width and parity are shared parameters
`timescale 1ns/10ps
module ppsw_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // serial pins
  input wire logic serial_in_line_i,
  output logic serial_out_line_o,
  input wire logic wake_hold_input_n_i,
  // reserved terminals, ignored
  input wire logic [1:0] reserved_pad_i,
  // configuration
  input wire logic [15:0] bit_divisor_i,
  // transmit stream from the host logic
  input wire logic tx_valid_i,
  input wire logic [ppsw_pkg::DATA_BITS-1:0] tx_data_i,
  output logic tx_ready_o,
  // receive stream to the host logic
  output logic rx_valid_o,
  output logic [ppsw_pkg::DATA_BITS-1:0] rx_data_o,
  output logic rx_parity_err_o,
  output logic rx_frame_err_o,
  input wire logic rx_ready_i,
  // power state
  output logic sleep_o
);
  localparam int DB = ppsw_pkg::DATA_BITS;
  typedef struct packed {
    ppsw_pkg::ppsw_state_t tx_st;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [DB:0] tx_sh;
    logic tx_line;
    ppsw_pkg::ppsw_state_t rx_st;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [DB:0] rx_sh;
    logic rx_valid;
    logic [DB-1:0] rx_data;
    logic rx_perr;
    logic rx_ferr;
    logic [ppsw_pkg::IDLE_W-1:0] idle_cnt;
    logic sleep;
    logic tx_ready;
  } ppsw_st_t;
  ppsw_st_t r;
  ppsw_st_t next_r;
  logic [15:0] div;
  logic unused_reserved;
  logic active;
  ppsw_fifo_if #(.W(DB)) fin();
  ppsw_fifo_if #(.W(DB)) fout();
  // reserved pads feed only the unused net unused_reserved
  assign unused_reserved = ^reserved_pad_i; // [RL11]
  // divisor floor of two keeps the half-bit count non-zero
  assign div = (bit_divisor_i < 16'h0002) ? 16'h0002 : bit_divisor_i; // [RL12]
  // transmit fifo in the data path
  assign fin.valid = tx_valid_i;
  assign fin.data = tx_data_i;
  ppsw_fifo #(
    .W(DB),
    .DEPTH(ppsw_pkg::FIFO_DEPTH),
    .AW(ppsw_pkg::FIFO_AW)
  ) u_txq (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_s(fin.snk),
    .out_s(fout.src)
  );
  // fifo drained only while awake and idle in transmit
  assign fout.ready = (r.tx_st == ppsw_pkg::PPSW_IDLE) && !r.sleep;
  assign active = fout.valid || (r.tx_st != ppsw_pkg::PPSW_IDLE)
    || (r.rx_st != ppsw_pkg::PPSW_IDLE) || r.rx_valid;
  // next-state logic for transmitter, receiver and sleep control
  always_comb begin
    next_r = r;
    next_r.tx_ready = fin.ready;
    // transmitter
    case (r.tx_st)
      ppsw_pkg::PPSW_IDLE: begin
        next_r.tx_line = ppsw_pkg::LINE_IDLE; // [RL1]
        if (fout.valid && fout.ready) begin
          next_r.tx_sh = {(^fout.data) ^ ppsw_pkg::PARITY_ODD, fout.data}; // [RL13]
          next_r.tx_st = ppsw_pkg::PPSW_START;
          next_r.tx_cnt = div - 16'h0001;
          next_r.tx_line = ppsw_pkg::LINE_START; // [RL2]
        end
      end
      ppsw_pkg::PPSW_START: begin
        if (r.tx_cnt == 16'h0000) begin
          next_r.tx_st = ppsw_pkg::PPSW_BITS;
          next_r.tx_cnt = div - 16'h0001;
          next_r.tx_bit = 4'h0;
          next_r.tx_line = r.tx_sh[0]; // [RL3] [RL4] [RL13]
          next_r.tx_sh = r.tx_sh >> 1;
        end else begin
          next_r.tx_cnt = r.tx_cnt - 16'h0001;
        end
      end
      ppsw_pkg::PPSW_BITS: begin
        if (r.tx_cnt == 16'h0000) begin
          next_r.tx_cnt = div - 16'h0001;
          if (r.tx_bit == ppsw_pkg::NBITS_FRAME - 4'h1) begin
            next_r.tx_st = ppsw_pkg::PPSW_STOP;
            next_r.tx_line = ppsw_pkg::LINE_IDLE; // [RL5]
          end else begin
            next_r.tx_bit = r.tx_bit + 4'h1;
            next_r.tx_line = r.tx_sh[0]; // [RL3] [RL4]
            next_r.tx_sh = r.tx_sh >> 1;
          end
        end else begin
          next_r.tx_cnt = r.tx_cnt - 16'h0001;
        end
      end
      ppsw_pkg::PPSW_STOP: begin
        if (r.tx_cnt == 16'h0000) begin
          next_r.tx_st = ppsw_pkg::PPSW_IDLE;
        end else begin
          next_r.tx_cnt = r.tx_cnt - 16'h0001;
        end
      end
      default: begin
        next_r.tx_st = ppsw_pkg::PPSW_IDLE;
        next_r.tx_line = ppsw_pkg::LINE_IDLE;
      end
    endcase
    // receive output handshake
    if (r.rx_valid && rx_ready_i) begin
      next_r.rx_valid = 1'b0;
    end
    // receiver, sampling mid bit
    case (r.rx_st)
      ppsw_pkg::PPSW_IDLE: begin
        if (serial_in_line_i == ppsw_pkg::LINE_START && !r.sleep) begin // [RL7]
          next_r.rx_st = ppsw_pkg::PPSW_START;
          next_r.rx_cnt = (div >> 1) - 16'h0001; // [RL12]
        end
      end
      ppsw_pkg::PPSW_START: begin
        if (r.rx_cnt == 16'h0000) begin
          if (serial_in_line_i == ppsw_pkg::LINE_START) begin
            next_r.rx_st = ppsw_pkg::PPSW_BITS;
            next_r.rx_cnt = div - 16'h0001;
            next_r.rx_bit = 4'h0;
          end else begin
            next_r.rx_st = ppsw_pkg::PPSW_IDLE; // glitch, not a start bit
          end
        end else begin
          next_r.rx_cnt = r.rx_cnt - 16'h0001;
        end
      end
      ppsw_pkg::PPSW_BITS: begin
        if (r.rx_cnt == 16'h0000) begin
          next_r.rx_cnt = div - 16'h0001;
          next_r.rx_sh = {serial_in_line_i, r.rx_sh[DB:1]}; // [RL13]
          if (r.rx_bit == ppsw_pkg::NBITS_FRAME - 4'h1) begin
            next_r.rx_st = ppsw_pkg::PPSW_STOP;
          end else begin
            next_r.rx_bit = r.rx_bit + 4'h1;
          end
        end else begin
          next_r.rx_cnt = r.rx_cnt - 16'h0001;
        end
      end
      ppsw_pkg::PPSW_STOP: begin
        if (r.rx_cnt == 16'h0000) begin
          next_r.rx_st = ppsw_pkg::PPSW_IDLE;
          next_r.rx_valid = 1'b1; // overwrites an unread word
          next_r.rx_data = r.rx_sh[DB-1:0];
          next_r.rx_perr = (^r.rx_sh) != ppsw_pkg::PARITY_ODD;
          next_r.rx_ferr = (serial_in_line_i != ppsw_pkg::LINE_IDLE); // [RL7]
        end else begin
          next_r.rx_cnt = r.rx_cnt - 16'h0001;
        end
      end
      default: begin
        next_r.rx_st = ppsw_pkg::PPSW_IDLE;
      end
    endcase
    // sleep control: wake hold forces awake and clears idle time
    if (!wake_hold_input_n_i) begin
      next_r.sleep = 1'b0; // [RL8]
      next_r.idle_cnt = '0; // [RL9]
    end else if (active) begin
      next_r.idle_cnt = '0;
    end else if (r.idle_cnt == ppsw_pkg::IDLE_W'(ppsw_pkg::IDLE_CYCLES - 1)) begin
      next_r.sleep = 1'b1;
    end else begin
      next_r.idle_cnt = r.idle_cnt + 1'b1;
    end
  end
  // state register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      r <= '0;
      r.tx_line <= ppsw_pkg::LINE_IDLE;
      r.tx_st <= ppsw_pkg::PPSW_IDLE;
      r.rx_st <= ppsw_pkg::PPSW_IDLE;
    end else begin
      r <= next_r;
    end
  end
  // registered outputs
  assign serial_out_line_o = r.tx_line;
  assign tx_ready_o = r.tx_ready;
  assign rx_valid_o = r.rx_valid;
  assign rx_data_o = r.rx_data;
  assign rx_parity_err_o = r.rx_perr;
  assign rx_frame_err_o = r.rx_ferr;
  assign sleep_o = r.sleep;
endmodule : ppsw_top

//--- testbench/ppsw_chk.sv
// checker for ppsw_top: frame timing, wake and receive stream
// assumes bind onto ppsw_top, one clock, synchronous active-low reset
`timescale 1ns/10ps
module ppsw_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // pins and configuration
  input wire logic serial_in_line_i,
  input wire logic serial_out_line_o,
  input wire logic wake_hold_input_n_i,
  input wire logic [1:0] reserved_pad_i,
  input wire logic [15:0] bit_divisor_i,
  // streams and power state
  input wire logic tx_valid_i,
  input wire logic [ppsw_pkg::DATA_BITS-1:0] tx_data_i,
  input wire logic tx_ready_o,
  input wire logic rx_valid_o,
  input wire logic [ppsw_pkg::DATA_BITS-1:0] rx_data_o,
  input wire logic rx_parity_err_o,
  input wire logic rx_frame_err_o,
  input wire logic rx_ready_i,
  input wire logic sleep_o
);
  logic prev_out;
  logic [19:0] pos;
  logic [19:0] div;
  // divisor as the design uses it, small values act as 2
  assign div = (bit_divisor_i < 16'h0002) ? 20'h00002 : 20'(bit_divisor_i);
  // cycle position inside an outgoing frame, 0 when idle
  always_ff @(posedge clk_i) begin
    prev_out <= serial_out_line_o;
    if (!reset_n_i || pos == div * 20'h0000b - 20'h00001) begin
      pos <= 20'h00000;
    end else if (pos != 20'h00000 || (prev_out && !serial_out_line_o)) begin
      pos <= pos + 20'h00001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_start_low: assert property (pos != 0 && pos < div |-> !serial_out_line_o)
    else $error("start bit short");
  chk_stop_high: assert property (pos >= div * 20'h0000a |-> serial_out_line_o)
    else $error("stop bit not high");
  chk_wake_awake: assert property (!wake_hold_input_n_i |=> !sleep_o)
    else $error("asleep while wake held");
  chk_asleep_idle: assert property (sleep_o |-> serial_out_line_o)
    else $error("line low while asleep");
  chk_rx_hold: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o)
    else $error("word dropped unread");
  chk_rx_stop: assert property ($rose(rx_valid_o) && !rx_frame_err_o |->
    $past(serial_in_line_i)) else $error("word without stop");
  chk_reset_vals: assert property ($rose(reset_n_i) |->
    serial_out_line_o && !rx_valid_o && !sleep_o) else $error("bad reset state");
  chk_ready_up: assert property ($rose(reset_n_i) |-> ##[1:3] tx_ready_o)
    else $error("not ready after reset");
endmodule : ppsw_chk
bind ppsw_top ppsw_chk chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .serial_in_line_i(serial_in_line_i), .serial_out_line_o(serial_out_line_o),
  .wake_hold_input_n_i(wake_hold_input_n_i), .reserved_pad_i(reserved_pad_i),
  .bit_divisor_i(bit_divisor_i), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
  .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
  .rx_parity_err_o(rx_parity_err_o), .rx_frame_err_o(rx_frame_err_o),
  .rx_ready_i(rx_ready_i), .sleep_o(sleep_o));

//--- testbench/ppsw_client.sv
// client model: sends frames on the receive pin, holds wake low
// assumes the caller passes the bit divisor the device uses
`timescale 1ns/10ps
module ppsw_client (
  // clock
  input wire logic clk_i,
  // pins toward the device
  output logic serial_in_line_o,
  output logic wake_hold_n_o
);
  // idle high, wake released until a session starts
  initial begin
    serial_in_line_o = 1'b1;
    wake_hold_n_o = 1'b1;
  end
  // one frame, optionally with wrong parity or a low stop bit
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop,
                      input int div);
    logic [10:0] f;
    f = {~bad_stop, ^d ^ bad_par, d, 1'b0};
    @(posedge clk_i);
    wake_hold_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    for (int b = 0; b < 11; b++) begin
      serial_in_line_o <= f[b];
      repeat (div) @(posedge clk_i);
    end
    serial_in_line_o <= 1'b1;
  endtask : send
endmodule : ppsw_client

//--- testbench/ppsw_top_test.sv
// self-checking bench for ppsw_top with a client model
// assumes ppsw_client drives the receive and wake pins
`timescale 1ns/10ps
module ppsw_top_test;
  localparam int DIV = 8;
  typedef struct packed { logic [7:0] d; logic p; } ppsw_row_t;
  ppsw_row_t rows [5] = '{'{8'h01, 1'b1}, '{8'h80, 1'b1}, '{8'ha5, 1'b0},
                          '{8'hff, 1'b0}, '{8'h6e, 1'b1}};
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic tx_valid_i = 1'b0;
  logic rx_ready_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic [1:0] reserved_pad_i = 2'h0;
  logic serial_out_line_o, tx_ready_o, rx_valid_o, rx_parity_err_o, rx_frame_err_o;
  logic sleep_o, sin, wake_n, par, fill_done;
  logic [7:0] rx_data_o, got;
  int n_errors = 0;
  int compares = 0;
  int n = 0;
  // device and client
  ppsw_top dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .serial_in_line_i(sin),
    .serial_out_line_o(serial_out_line_o), .wake_hold_input_n_i(wake_n),
    .reserved_pad_i(reserved_pad_i), .bit_divisor_i(16'(DIV)), .tx_valid_i(tx_valid_i),
    .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
    .rx_data_o(rx_data_o), .rx_parity_err_o(rx_parity_err_o),
    .rx_frame_err_o(rx_frame_err_o), .rx_ready_i(rx_ready_i), .sleep_o(sleep_o));
  ppsw_client cli_u (.clk_i(clk_i), .serial_in_line_o(sin), .wake_hold_n_o(wake_n));
  // clock and reserved pads that keep changing
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) reserved_pad_i <= reserved_pad_i + 2'h1;
  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : check
  // level of a watched output: 0 transmit line, 1 receive valid, 2 transmit ready
  function automatic logic lvl_of(input int sel);
    return (sel == 0) ? serial_out_line_o : (sel == 1) ? rx_valid_o : tx_ready_o;
  endfunction : lvl_of
  // bounded wait for a level, no reference to a port-driven variable
  task automatic wait_lvl(input int sel, input logic lvl);
    for (int i = 0; i < 4000 && lvl_of(sel) !== lvl; i++) @(negedge clk_i);
    if (lvl_of(sel) !== lvl) begin
      n_errors++;
      $display("mismatch at %0t: wait ran out", $time);
      complete_run();
    end
  endtask : wait_lvl
  task automatic put_word(input logic [7:0] d);
    @(posedge clk_i);
    tx_valid_i <= 1'b1;
    tx_data_i <= d;
    @(posedge clk_i);
    tx_valid_i <= 1'b0;
  endtask : put_word
  // decode one frame from the transmit line at mid bit
  task automatic get_frame(output logic [7:0] d, output logic p);
    wait_lvl(0, 1'b0);
    repeat (DIV / 2) @(negedge clk_i);
    check({7'h00, serial_out_line_o}, 8'h00);
    for (int b = 0; b < 10; b++) begin
      repeat (DIV) @(negedge clk_i);
      if (b < 8) d[b] = serial_out_line_o;
      if (b == 8) p = serial_out_line_o;
    end
    check({7'h00, serial_out_line_o}, 8'h01);
  endtask : get_frame
  task automatic take_rx(input logic [7:0] d, input logic [7:0] flags);
    @(negedge clk_i); // look at outputs away from the launching edge
    wait_lvl(1, 1'b1);
    check(rx_data_o, d);
    check({6'h00, rx_parity_err_o, rx_frame_err_o}, flags);
    @(posedge clk_i);
    rx_ready_i <= 1'b1;
    @(posedge clk_i);
    rx_ready_i <= 1'b0;
    @(negedge clk_i);
    check({7'h00, rx_valid_o}, 8'h00);
  endtask : take_rx
  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wait_lvl(2, 1'b1);
    // ordinary words each way
    foreach (rows[i]) begin
      put_word(rows[i].d);
      get_frame(got, par);
      check(got, rows[i].d);
      check({7'h00, par}, {7'h00, rows[i].p});
      cli_u.send(rows[i].d, 1'b0, 1'b0, DIV);
      take_rx(rows[i].d, 8'h00);
    end
    // fill the buffer until refused while frames drain back to back
    fill_done = 1'b0;
    fork
      begin
        for (int k = 0; k < 12 && tx_ready_o === 1'b1; k++) begin
          put_word(8'h10 + 8'(k));
          n++;
          repeat (2) @(negedge clk_i);
        end
        check({7'h00, tx_ready_o}, 8'h00);
        fill_done = 1'b1;
      end
      for (int k = 0; !(fill_done && k >= n); k++) begin
        get_frame(got, par);
        check(got, 8'h10 + 8'(k));
      end
    join
    // parity error, then stop error
    cli_u.send(8'h5a, 1'b1, 1'b0, DIV);
    take_rx(8'h5a, 8'h02);
    cli_u.send(8'h5a, 1'b0, 1'b1, DIV);
    take_rx(8'h5a, 8'h01);
    check({7'h00, sleep_o}, 8'h00);
    // reset with a word left unread
    cli_u.send(8'h77, 1'b0, 1'b0, DIV);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(negedge clk_i);
    check({6'h00, serial_out_line_o, rx_valid_o}, 8'h02);
    // let the edges after release pass so the checker sees them too
    repeat (2) @(negedge clk_i);
    check({6'h00, tx_ready_o, rx_valid_o}, 8'h02);
    repeat (4) @(negedge clk_i);
    complete_run();
  end
endmodule : ppsw_top_test
